// >>> core/cmp_pkg.sv
// Shared constants and types for the dual comparator control unit
package cmp_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] CFG_OFS  = 4'h0;
  localparam logic [3:0] FLAG_OFS = 4'h4;
  localparam logic [3:0] CTRL_OFS = 4'h8;
  localparam logic [3:0] STAT_OFS = 4'hC;

  // Comparator mode codes
  localparam logic [2:0] MODE_OFF     = 3'h0;
  localparam logic [2:0] MODE_MUX3    = 3'h1;
  localparam logic [2:0] MODE_MUX4    = 3'h2;
  localparam logic [2:0] MODE_PIN_OUT = 3'h6;
  localparam logic [2:0] MODE_OFF_DIG = 3'h7;

  // Field positions in flag and status words
  localparam int FLAG_A_BIT   = 0;
  localparam int FLAG_B_BIT   = 1;
  localparam int STAT_MM_A    = 0;
  localparam int STAT_MM_B    = 1;
  localparam int STAT_SETTLED = 2;
  localparam int STAT_SLEEP   = 3;

  // Values after reset, and the all-digital pin setting of mode 111
  localparam logic [7:0]  CFG_RESET   = 8'h00;
  localparam logic [1:0]  FLAG_RESET  = 2'h0;
  localparam logic [3:0]  CTRL_RESET  = 4'h0;
  localparam logic [3:0]  ANALOG_ALL  = 4'hF;
  localparam logic [3:0]  ANALOG_NONE = 4'h0;
  localparam logic [31:0] RDATA_IDLE  = 32'h0000_0000;

  // Four system clock phases per cycle, phase one first
  localparam logic [1:0] PHASE_ONE = 2'h0;
  localparam logic [1:0] PHASE_STEP = 2'h1;

  // Bias settling time after a comparator is first enabled
  localparam int CLK_PERIOD_NS  = 20;
  localparam int BIAS_SETTLE_NS = 1000;
  localparam logic [5:0] SETTLE_CYCLES =
    6'((BIAS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0] SETTLE_STEP = 6'h01;
  localparam logic [5:0] SETTLE_ZERO = 6'h00;

  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;

  typedef struct packed {
    logic       out_b;
    logic       out_a;
    logic       inv_b;
    logic       inv_a;
    logic       inv_input_select;
    logic [2:0] cmp_mode_sel;
  } comparator_config_t;

  typedef struct packed {
    logic global_irq_gate;
    logic periph_irq_gate;
    logic cmp_b_irq_enable;
    logic cmp_a_irq_enable;
  } irq_control_reg_t;

  typedef struct packed {
    logic       a_pin;
    logic       a_oe;
    logic       b_pin;
    logic       b_oe;
    logic       a_inv_sel;
    logic       b_inv_sel;
    logic       power;
    logic [3:0] analog;
    logic       irq;
    logic       wake;
  } pin_state_t;

  typedef struct packed {
    logic held_ref;
    logic sampled;
  } mm_state_t;

endpackage

// >>> core/mismatch_latch.sv
// Change detector of one comparator: reference latch, phase-one latch, xor
`timescale 1ns/1ps
module mismatch_latch
  import cmp_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic sample_i,
  input  wire logic capture_i,
  input  wire logic out_bit_i,
  output logic      mismatch_o
);

  mm_state_t st;
  mm_state_t next_st;

  always_comb begin
    next_st = st;
    // Coinciding capture and sample both take the new level, so no mismatch
    if (capture_i) begin
      next_st.held_ref = out_bit_i;
    end
    if (sample_i) begin
      next_st.sampled = out_bit_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Ends by itself when the output returns to the referenced level
  assign mismatch_o = st.held_ref ^ st.sampled;

endmodule

// >>> core/comparator_ctrl.sv
// Dual comparator control, change detection and interrupt request logic
//
// Operation
// - Output bit is 1 when noninv input exceeds inv input, inverted by polarity bit.
// - Status bit and output pin carry the same value.
// - Input select switches inv input: comparator a in mode 001, both in 010.
// - In switch modes both candidate pins stay analog whatever is selected.
// - Flag sets on output change, seen by xor of two latches.
// - Reference latch captures output on each config read, holds until next read.
// - Second latch samples output every phase one; a change makes a mismatch.
// - Flag held set while mismatch lasts; read or output reverting ends it.
// - Any config write also ends the mismatch through its internal read.
// - Software clears flag by writing 0; writing 1 sets it.
// - Request needs comparator, peripheral and global enables; flag sets regardless.
// - Clearing the flag has no effect while a mismatch remains.
// - Change coinciding with a config read may fail to set the flag.
// - Enabled comparators keep working and detecting changes during sleep.
// - Modes 000 and 111 turn the comparators off.
// - Change wakes from sleep with comparator and peripheral enables, ignoring global.
// - After wake the next instruction runs first, then the service routine.
// - Reset returns config to mode 000, comparators off, inputs analog.
// - Outputs reach external pins only in mode 110.
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module comparator_ctrl
  import cmp_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        cmp_a_raw_i,
  input  wire logic        cmp_b_raw_i,
  input  wire logic        sleep_i,
  output logic             cmp_a_pin_o,
  output logic             cmp_a_pin_oe_o,
  output logic             cmp_b_pin_o,
  output logic             cmp_b_pin_oe_o,
  output logic             cmp_a_inv_sel_o,
  output logic             cmp_b_inv_sel_o,
  output logic             cmp_power_o,
  output logic      [3:0]  pin_analog_o,
  output logic             irq_o,
  output logic             wake_o
);

  typedef struct packed {
    bus_state_t         bus;
    logic               waitreq;
    logic [31:0]        rdata;
    comparator_config_t cfg;
    logic [1:0]         cmp_irq_flag;
    irq_control_reg_t   ctrl;
    logic [1:0]         phase;
    logic [1:0]         sync1;
    logic [1:0]         sync2;
    logic [1:0]         sync3;
    logic [1:0]         stable;
    logic [5:0]         settle_cnt;
    logic               settled;
    pin_state_t         pins;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;

  logic [1:0] mismatch;
  logic       cfg_touch;
  logic       phase_one;

  function automatic logic mode_on(input logic [2:0] mode);
    mode_on = (mode != MODE_OFF) && (mode != MODE_OFF_DIG);
  endfunction

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Config read or write; a write starts with an internal read
  assign cfg_touch = (st.bus == BUS_IDLE) && (avs_read_i || avs_write_i)
                     && hit(avs_address_i, CFG_OFS);
  assign phase_one = (st.phase == PHASE_ONE);

  mismatch_latch detect_a (
    .sys_clk_i  (sys_clk_i),
    .reset_i    (reset_i),
    .sample_i   (phase_one),
    .capture_i  (cfg_touch),
    .out_bit_i  (st.cfg.out_a),
    .mismatch_o (mismatch[0])
  );

  mismatch_latch detect_b (
    .sys_clk_i  (sys_clk_i),
    .reset_i    (reset_i),
    .sample_i   (phase_one),
    .capture_i  (cfg_touch),
    .out_bit_i  (st.cfg.out_b),
    .mismatch_o (mismatch[1])
  );

  always_comb begin
    logic       power;
    logic       nxt_power;
    logic [1:0] pending;
    logic [2:0] mode;
    power     = 1'b0;
    nxt_power = 1'b0;
    pending   = 2'h0;
    mode      = MODE_OFF;
    next_st   = st;

    // Analog results arrive asynchronously; accept a level once stable
    next_st.sync1 = {cmp_b_raw_i, cmp_a_raw_i};
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    for (int i = 0; i < 2; i++) begin
      if (st.sync2[i] == st.sync3[i]) begin
        next_st.stable[i] = st.sync2[i];
      end
    end

    next_st.phase = st.phase + PHASE_STEP;

    // Read data valid only during the acknowledge cycle
    next_st.rdata = RDATA_IDLE;

    case (st.bus)
      BUS_IDLE: begin
        next_st.waitreq = 1'b1;
        if (avs_read_i || avs_write_i) begin
          next_st.bus     = BUS_ACK;
          next_st.waitreq = 1'b0;
          if (avs_read_i) begin
            if (hit(avs_address_i, CFG_OFS)) begin
              next_st.rdata = {24'h00_0000, st.cfg};
            end else if (hit(avs_address_i, FLAG_OFS)) begin
              next_st.rdata = {30'h0000_0000, st.cmp_irq_flag};
            end else if (hit(avs_address_i, CTRL_OFS)) begin
              next_st.rdata = {28'h000_0000, st.ctrl};
            end else if (hit(avs_address_i, STAT_OFS)) begin
              next_st.rdata[STAT_MM_A]    = mismatch[0];
              next_st.rdata[STAT_MM_B]    = mismatch[1];
              next_st.rdata[STAT_SETTLED] = st.settled;
              next_st.rdata[STAT_SLEEP]   = sleep_i;
            end
          end
        end
      end
      BUS_ACK: begin
        next_st.bus     = BUS_IDLE;
        next_st.waitreq = 1'b1;
        if (avs_write_i && avs_byteenable_i[0]) begin
          if (hit(avs_address_i, CFG_OFS)) begin
            // Status bits ignore writes
            next_st.cfg.inv_b            = avs_writedata_i[5];
            next_st.cfg.inv_a            = avs_writedata_i[4];
            next_st.cfg.inv_input_select = avs_writedata_i[3];
            next_st.cfg.cmp_mode_sel     = avs_writedata_i[2:0];
          end else if (hit(avs_address_i, FLAG_OFS)) begin
            next_st.cmp_irq_flag = avs_writedata_i[1:0];
          end else if (hit(avs_address_i, CTRL_OFS)) begin
            next_st.ctrl = avs_writedata_i[3:0];
          end
        end
      end
      default: begin
        next_st.bus     = BUS_IDLE;
        next_st.waitreq = 1'b1;
      end
    endcase

    // Mismatch beats a software clear in the same cycle
    for (int i = 0; i < 2; i++) begin
      if (mismatch[i]) begin
        next_st.cmp_irq_flag[i] = 1'b1;
      end
    end

    // Detection keeps running while asleep; sleep gates nothing here
    power = mode_on(st.cfg.cmp_mode_sel);
    next_st.cfg.out_a = power & (st.stable[0] ^ st.cfg.inv_a);
    next_st.cfg.out_b = power & (st.stable[1] ^ st.cfg.inv_b);

    // Bias settle timer restarts whenever the comparators are off
    if (!power) begin
      next_st.settle_cnt = SETTLE_ZERO;
      next_st.settled    = 1'b0;
    end else if (!st.settled) begin
      if (st.settle_cnt == SETTLE_CYCLES - SETTLE_STEP) begin
        next_st.settled = 1'b1;
      end else begin
        next_st.settle_cnt = st.settle_cnt + SETTLE_STEP;
      end
    end

    // Pin side follows the next register values to stay in step
    mode      = next_st.cfg.cmp_mode_sel;
    nxt_power = mode_on(mode);
    next_st.pins.power = nxt_power;
    next_st.pins.a_pin = next_st.cfg.out_a;
    next_st.pins.b_pin = next_st.cfg.out_b;
    next_st.pins.a_oe  = (mode == MODE_PIN_OUT);
    next_st.pins.b_oe  = (mode == MODE_PIN_OUT);
    next_st.pins.a_inv_sel = ((mode == MODE_MUX3) || (mode == MODE_MUX4))
                             && next_st.cfg.inv_input_select;
    next_st.pins.b_inv_sel = (mode == MODE_MUX4)
                             && next_st.cfg.inv_input_select;
    // Only the digital off mode releases the inputs from analog use
    next_st.pins.analog = (mode == MODE_OFF_DIG) ? ANALOG_NONE : ANALOG_ALL;

    pending[0] = next_st.cmp_irq_flag[0] & next_st.ctrl.cmp_a_irq_enable;
    pending[1] = next_st.cmp_irq_flag[1] & next_st.ctrl.cmp_b_irq_enable;
    // Wake ignores the global gate
    next_st.pins.wake = sleep_i && (|pending) && next_st.ctrl.periph_irq_gate;
    // Request held off while asleep so the core resumes before servicing
    next_st.pins.irq  = !sleep_i && (|pending) && next_st.ctrl.periph_irq_gate
                        && next_st.ctrl.global_irq_gate;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st              <= '0;
      st.bus          <= BUS_IDLE;
      st.waitreq      <= 1'b1;
      st.cfg          <= CFG_RESET;
      st.cmp_irq_flag <= FLAG_RESET;
      st.ctrl         <= CTRL_RESET;
      st.pins.analog  <= ANALOG_ALL;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata_o    = st.rdata;
  assign avs_waitrequest_o = st.waitreq;
  assign cmp_a_pin_o       = st.pins.a_pin;
  assign cmp_a_pin_oe_o    = st.pins.a_oe;
  assign cmp_b_pin_o       = st.pins.b_pin;
  assign cmp_b_pin_oe_o    = st.pins.b_oe;
  assign cmp_a_inv_sel_o   = st.pins.a_inv_sel;
  assign cmp_b_inv_sel_o   = st.pins.b_inv_sel;
  assign cmp_power_o       = st.pins.power;
  assign pin_analog_o      = st.pins.analog;
  assign irq_o             = st.pins.irq;
  assign wake_o            = st.pins.wake;

endmodule

// >>> test/comparator_ctrl_assertions.sv
// Port-level assertions for the comparator control unit
`timescale 1ns/1ps
module comparator_ctrl_assertions (
  input wire logic        sys_clk_i,
  input wire logic        reset_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        sleep_i,
  input wire logic        cmp_a_pin_oe_o,
  input wire logic        cmp_b_pin_oe_o,
  input wire logic        cmp_a_inv_sel_o,
  input wire logic        cmp_b_inv_sel_o,
  input wire logic        cmp_power_o,
  input wire logic [3:0]  pin_analog_o,
  input wire logic        irq_o,
  input wire logic        wake_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  chk_one_wait: assert property (s_req |=> s_ack)
    else $error("waitrequest not low for exactly one cycle");
  chk_rdata_idle: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0)
    else $error("read data not zero outside answer");
  chk_irq_asleep: assert property ($past(sleep_i) |-> !irq_o)
    else $error("request raised while asleep");
  chk_wake_awake: assert property (!$past(sleep_i) |-> !wake_o)
    else $error("wake raised while awake");
  chk_irq_wake: assert property (!(irq_o && wake_o))
    else $error("request and wake together");
  chk_oe_pair: assert property (cmp_a_pin_oe_o == cmp_b_pin_oe_o)
    else $error("pin enables differ");
  chk_oe_power: assert property (cmp_a_pin_oe_o |-> cmp_power_o)
    else $error("pin driven with comparators off");
  chk_digital_off: assert property (pin_analog_o == 4'h0 |-> !cmp_power_o)
    else $error("digital pins with comparators on");
  chk_sel_pair: assert property (cmp_b_inv_sel_o |-> cmp_a_inv_sel_o)
    else $error("second switch without first");
endmodule
bind comparator_ctrl comparator_ctrl_assertions u_comparator_ctrl_assertions (
  .sys_clk_i, .reset_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
  .sleep_i, .cmp_a_pin_oe_o, .cmp_b_pin_oe_o, .cmp_a_inv_sel_o, .cmp_b_inv_sel_o,
  .cmp_power_o, .pin_analog_o, .irq_o, .wake_o);

// >>> test/analog_cmp_model.sv
// Behavioural model of the two analog comparator cores
`timescale 1ns/1ps
module analog_cmp_model (
  input  wire logic [7:0] a_pos_i,
  input  wire logic [7:0] b_pos_i,
  input  wire logic [7:0] neg_main_i,
  input  wire logic [7:0] neg_alt_i,
  input  wire logic       a_sel_i,
  input  wire logic       b_sel_i,
  output logic            a_raw_o,
  output logic            b_raw_o
);
  // Switch picks the alternate inverting pin
  assign a_raw_o = a_pos_i > (a_sel_i ? neg_alt_i : neg_main_i);
  assign b_raw_o = b_pos_i > (b_sel_i ? neg_alt_i : neg_main_i);
endmodule

// >>> test/test_comparator_ctrl.sv
// Self-checking bench for the comparator control unit
`timescale 1ns/1ps
module test_comparator_ctrl;
  import cmp_pkg::*;
  logic        sys_clk_i, reset_i, rd, wr, sleep, a_raw, b_raw, pa, poa, pb, pob;
  logic        sel_a, sel_b, power, irq, wake, wreq;
  logic [3:0]  addr, analog;
  logic [31:0] wdata, rdata, q;
  logic [7:0]  a_pos, b_pos, neg0, neg1;
  int          err_total, check_count, cycles;

  comparator_ctrl u_comparator_ctrl (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .cmp_a_raw_i(a_raw), .cmp_b_raw_i(b_raw), .sleep_i(sleep), .cmp_a_pin_o(pa),
    .cmp_a_pin_oe_o(poa), .cmp_b_pin_o(pb), .cmp_b_pin_oe_o(pob), .cmp_a_inv_sel_o(sel_a),
    .cmp_b_inv_sel_o(sel_b), .cmp_power_o(power), .pin_analog_o(analog), .irq_o(irq),
    .wake_o(wake));
  analog_cmp_model u_analog_cmp_model (.a_pos_i(a_pos), .b_pos_i(b_pos), .neg_main_i(neg0),
    .neg_alt_i(neg1), .a_sel_i(sel_a), .b_sel_i(sel_b), .a_raw_o(a_raw), .b_raw_o(b_raw));

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    addr  <= a;
    rd    <= !w;
    wr    <= w;
    wdata <= {24'h0, d};
    do @(posedge sys_clk_i); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // Let an edge pass so a following call never reassigns in this step
    @(posedge sys_clk_i);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(q, {24'h0, e});
  endtask
  // Long enough for sync, phase one and flag update
  task automatic settle();
    repeat (16) @(posedge sys_clk_i);
  endtask

  task automatic t_reset();
    rd_chk(CFG_OFS, 8'h00);
    rd_chk(FLAG_OFS, 8'h00);
    rd_chk(CTRL_OFS, 8'h00);
    rd_chk(4'h2, 8'h00);
    check(power, 1'b0);
    check(analog, ANALOG_ALL);
    $display("t_reset done");
  endtask
  task automatic t_polarity();
    bus(1'b1, CFG_OFS, 8'h06);
    settle();
    rd_chk(CFG_OFS, 8'h46);
    check({pb, pa, pob, poa}, 4'h7);
    bus(1'b1, CFG_OFS, 8'hF6);
    settle();
    rd_chk(CFG_OFS, 8'hB6);
    check({pb, pa}, 2'h2);
    $display("t_polarity done");
  endtask
  task automatic t_switch();
    bus(1'b1, CFG_OFS, 8'h09);
    settle();
    check({sel_b, sel_a}, 2'h1);
    rd_chk(CFG_OFS, 8'h09);
    check(analog, ANALOG_ALL);
    bus(1'b1, CFG_OFS, 8'h01);
    settle();
    rd_chk(CFG_OFS, 8'h41);
    bus(1'b1, CFG_OFS, 8'h0A);
    settle();
    check({sel_b, sel_a, analog}, 6'h3F);
    bus(1'b1, CFG_OFS, 8'h07);
    settle();
    check({power, analog}, 5'h00);
    bus(1'b1, CFG_OFS, 8'h00);
    settle();
    check({power, analog}, 5'h0F);
    $display("t_switch done");
  endtask
  task automatic t_flag();
    bus(1'b1, CFG_OFS, 8'h06);
    repeat (60) @(posedge sys_clk_i);
    bus(1'b0, CFG_OFS, 8'h00);
    bus(1'b1, FLAG_OFS, 8'h00);
    bus(1'b1, CTRL_OFS, 8'h0F);
    a_pos <= 8'd50;
    settle();
    rd_chk(FLAG_OFS, 8'h01);
    check(irq, 1'b1);
    rd_chk(STAT_OFS, 8'h05);
    bus(1'b1, FLAG_OFS, 8'h00);
    rd_chk(FLAG_OFS, 8'h01);
    a_pos <= 8'd200;
    settle();
    rd_chk(STAT_OFS, 8'h04);
    bus(1'b1, FLAG_OFS, 8'h00);
    rd_chk(FLAG_OFS, 8'h00);
    b_pos <= 8'd200;
    settle();
    rd_chk(FLAG_OFS, 8'h02);
    bus(1'b1, CFG_OFS, 8'h06);
    rd_chk(STAT_OFS, 8'h04);
    // Flag alone does not say which way; software reads the levels itself
    rd_chk(CFG_OFS, 8'hC6);
    bus(1'b1, FLAG_OFS, 8'h00);
    rd_chk(FLAG_OFS, 8'h00);
    bus(1'b1, FLAG_OFS, 8'h01);
    rd_chk(FLAG_OFS, 8'h01);
    bus(1'b1, CTRL_OFS, 8'h07);
    @(posedge sys_clk_i);
    check(irq, 1'b0);
    bus(1'b1, FLAG_OFS, 8'h00);
    $display("t_flag done");
  endtask
  task automatic t_sleep();
    bus(1'b1, CTRL_OFS, 8'h05);
    sleep <= 1'b1;
    a_pos <= 8'd50;
    settle();
    check({wake, irq}, 2'h2);
    // Bias long settled, so the settled bit stands beside sleep
    rd_chk(STAT_OFS, 8'h0D);
    sleep <= 1'b0;
    bus(1'b0, CFG_OFS, 8'h00);
    bus(1'b1, FLAG_OFS, 8'h00);
    @(posedge sys_clk_i);
    check({wake, irq}, 2'h0);
    $display("t_sleep done");
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // Cut a hang short well above the expected run
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    {rd, wr, sleep, addr, wdata} = '0;
    {a_pos, b_pos, neg0, neg1} = {8'd200, 8'd50, 8'd100, 8'd250};
    err_total = 0;
    check_count = 0;
    cycles = 0;
    reset_i = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    t_reset();
    t_polarity();
    t_switch();
    t_flag();
    t_sleep();
    end_sim();
  end
endmodule
